// File: src/lbd_consts.svh
// register offsets, field positions and reset values of the dma mode block
`ifndef LBD_CONSTS_SVH
`define LBD_CONSTS_SVH
`define LBD_OFF_CONFIG      12'h000
`define LBD_OFF_STATUS      12'h004
`define LBD_OFF_IRQ_STAT    12'h008
`define LBD_OFF_IRQ_MASK    12'h00C
`define LBD_BIT_MODE_A      0
`define LBD_BIT_MODE_B      1
`define LBD_BIT_SHARED      2
`define LBD_BIT_DIR         3
`define LBD_BIT_DEC1        4
`define LBD_BIT_DEC2        5
`define LBD_BIT_SEP_IRQ     6
`define LBD_CONFIG_W        7
`define LBD_CONFIG_RST      7'h00
`define LBD_EV_W            4
`define LBD_IRQ_MASK_RST    4'h0
`define LBD_RESP_OKAY       2'h0
`define LBD_RESP_SLVERR     2'h2
`endif

// File: src/lbd_pkg.sv
// types shared by the dma mode block
package lbd_pkg;
    typedef enum logic [2:0] {
        LBD_W_IDLE = 3'b001,
        LBD_W_RESP = 3'b010,
        LBD_W_HOLD = 3'b100
    } lbd_wstate_type;
    typedef struct packed {
        logic a_rx;
        logic a_tx;
        logic b_rx;
        logic b_tx;
    } lbd_req_type;
endpackage : lbd_pkg

// File: src/lbd_sync_if.sv
// carrier between the top and its pin synchroniser
`timescale 1ns/1ps
interface lbd_sync_if;
    logic [5:0] raw;
    logic [5:0] synced;
    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface : lbd_sync_if

// File: src/lbd_sync.sv
// two-stage synchroniser for local bus pins
`timescale 1ns/1ps
module lbd_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  aclk_en,
    lbd_sync_if.sync   port_s
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage1_nxt;
    logic [WIDTH-1:0] stage2_nxt;

    always_comb begin
        stage1_nxt = port_s.raw;
        stage2_nxt = stage1_r;
    end

    // first stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else if (aclk_en) begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
        end
    end

    assign port_s.synced = stage2_r;
endmodule : lbd_sync

// File: src/lbd_top.sv
// local bus dma service mode and interrupt pin configuration
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "lbd_consts.svh"
module lbd_top
    import lbd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        aclk_en,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        chan_a_request_line,
    input  wire logic        chan_a_rx_request,
    input  wire logic        chan_b_tx_request,
    input  wire logic        chan_b_rx_request,
    input  wire logic        local_irq_input_one,
    input  wire logic        local_irq_input_two,
    input  wire logic        dma_a_tx_grant,
    input  wire logic        dma_a_rx_grant,
    input  wire logic        dma_b_tx_grant,
    input  wire logic        dma_b_rx_grant,
    output logic             chan_a_ack_line,
    output logic             chan_a_rx_ack,
    output logic             chan_b_tx_ack,
    output logic             chan_b_rx_ack,
    output logic [3:0]       dma_req,
    output logic             chan_a_irq,
    output logic             chan_b_irq,
    output logic             chan_a_irq_alt_decode,
    output logic             chan_b_irq_alt_decode,
    output logic             irq
);
    // configuration and interrupt registers
    logic [`LBD_CONFIG_W-1:0] config_r;
    logic [`LBD_CONFIG_W-1:0] config_nxt;
    logic [`LBD_EV_W-1:0]     irq_stat_r;
    logic [`LBD_EV_W-1:0]     irq_stat_nxt;
    logic [`LBD_EV_W-1:0]     irq_mask_r;
    logic [`LBD_EV_W-1:0]     irq_mask_nxt;
    logic [`LBD_EV_W-1:0]     events;
    logic [1:0]               irq_lvl_r;
    logic [1:0]               irq_lvl_nxt;

    // write channel state
    lbd_wstate_type           wstate_r;
    lbd_wstate_type           wstate_nxt;
    logic                     aw_have_r;
    logic                     aw_have_nxt;
    logic                     w_have_r;
    logic                     w_have_nxt;
    logic [11:0]              waddr_r;
    logic [11:0]              waddr_nxt;
    logic [31:0]              wdata_r;
    logic [31:0]              wdata_nxt;
    logic                     wstrb0_r;
    logic                     wstrb0_nxt;
    logic                     bvalid_r;
    logic                     bvalid_nxt;
    logic [1:0]               bresp_r;
    logic [1:0]               bresp_nxt;
    logic                     wr_fire;

    // read channel state
    logic                     rvalid_r;
    logic                     rvalid_nxt;
    logic [31:0]              rdata_r;
    logic [31:0]              rdata_nxt;
    logic [1:0]               rresp_r;
    logic [1:0]               rresp_nxt;

    // outputs toward the peripheral and the dma engine
    lbd_req_type              req_r;
    lbd_req_type              req_nxt;
    logic [3:0]               ack_r;
    logic [3:0]               ack_nxt;

    logic mode_a;
    logic mode_b;
    logic shared_dma;
    logic shared_dma_direction;
    logic irq_in1_decode_select;
    logic irq_in2_decode_select;
    logic separate_irq_pins;
    logic irq1_act;
    logic irq2_act;

    lbd_sync_if sync_bus ();

    // request and interrupt pins pass two flip-flops before anything looks at them; grants are used directly
    assign sync_bus.raw = {local_irq_input_two, local_irq_input_one, chan_b_rx_request,
                           chan_b_tx_request, chan_a_rx_request, chan_a_request_line};

    lbd_sync #(
        .WIDTH (6)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .aclk_en (aclk_en),
        .port_s  (sync_bus.sync)
    );

    assign mode_a                = config_r[`LBD_BIT_MODE_A];
    assign mode_b                = config_r[`LBD_BIT_MODE_B];
    assign shared_dma            = config_r[`LBD_BIT_SHARED];
    assign shared_dma_direction  = config_r[`LBD_BIT_DIR];
    assign irq_in1_decode_select = config_r[`LBD_BIT_DEC1];
    assign irq_in2_decode_select = config_r[`LBD_BIT_DEC2];
    assign separate_irq_pins     = config_r[`LBD_BIT_SEP_IRQ];

    // alternate scheme samples the pin as active low
    assign irq1_act = sync_bus.synced[4] ^ irq_in1_decode_select;
    assign irq2_act = sync_bus.synced[5] ^ irq_in2_decode_select;

    // request routing and acknowledge fan-out
    always_comb begin
        req_nxt = '0;
        ack_nxt = 4'h0;
        if (mode_a) begin
            if (shared_dma) begin
                // direction bit names which direction the shared line asks for
                req_nxt.a_tx = sync_bus.synced[0] & shared_dma_direction;
                req_nxt.a_rx = sync_bus.synced[0] & ~shared_dma_direction;
                ack_nxt[0]   = dma_a_tx_grant | dma_a_rx_grant;
            end else begin
                req_nxt.a_tx = sync_bus.synced[0];
                req_nxt.a_rx = sync_bus.synced[1];
                ack_nxt[0]   = dma_a_tx_grant;
                ack_nxt[1]   = dma_a_rx_grant;
            end
        end
        // interrupt mode channels leave requests and acks idle
        if (mode_b) begin
            req_nxt.b_tx = sync_bus.synced[2];
            req_nxt.b_rx = sync_bus.synced[3];
            ack_nxt[2]   = dma_b_tx_grant;
            ack_nxt[3]   = dma_b_rx_grant;
        end
    end

    // interrupt pin assignment to channels
    always_comb begin
        if (separate_irq_pins) begin
            irq_lvl_nxt = {irq2_act, irq1_act};
        end else begin
            // input two is disabled, input one serves both channels
            irq_lvl_nxt = {irq1_act, irq1_act};
        end
    end

    assign events = {irq_lvl_nxt[1] & ~irq_lvl_r[1], irq_lvl_nxt[0] & ~irq_lvl_r[0],
                     req_nxt.b_tx | req_nxt.b_rx, req_nxt.a_tx | req_nxt.a_rx};

    // axi write path: address and data in either order, then response
    always_comb begin
        wstate_nxt   = wstate_r;
        aw_have_nxt  = aw_have_r;
        w_have_nxt   = w_have_r;
        waddr_nxt    = waddr_r;
        wdata_nxt    = wdata_r;
        wstrb0_nxt   = wstrb0_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        wr_fire      = 1'b0;
        config_nxt   = config_r;
        irq_mask_nxt = irq_mask_r;
        case (wstate_r)
            LBD_W_IDLE: begin
                if (s_axi_awvalid && !aw_have_r) begin
                    aw_have_nxt = 1'b1;
                    waddr_nxt   = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_have_r) begin
                    w_have_nxt = 1'b1;
                    wdata_nxt  = s_axi_wdata;
                    // strobe is kept with the data, the master may drop it once taken
                    wstrb0_nxt = s_axi_wstrb[0];
                end
                if (aw_have_r && w_have_r) begin
                    wstate_nxt = LBD_W_RESP;
                end
            end
            LBD_W_RESP: begin
                wr_fire     = 1'b1;
                bvalid_nxt  = 1'b1;
                bresp_nxt   = `LBD_RESP_OKAY;
                aw_have_nxt = 1'b0;
                w_have_nxt  = 1'b0;
                wstate_nxt  = LBD_W_HOLD;
                case ({waddr_r[11:2], 2'b00})
                    `LBD_OFF_CONFIG: begin
                        if (wstrb0_r) begin
                            config_nxt = wdata_r[`LBD_CONFIG_W-1:0];
                        end
                    end
                    `LBD_OFF_IRQ_MASK: begin
                        if (wstrb0_r) begin
                            irq_mask_nxt = wdata_r[`LBD_EV_W-1:0];
                        end
                    end
                    `LBD_OFF_IRQ_STAT, `LBD_OFF_STATUS: ;
                    default: bresp_nxt = `LBD_RESP_SLVERR;
                endcase
            end
            LBD_W_HOLD: begin
                if (s_axi_bready) begin
                    bvalid_nxt = 1'b0;
                    wstate_nxt = LBD_W_IDLE;
                end
            end
            default: wstate_nxt = LBD_W_IDLE;
        endcase
    end

    // sticky events: a set in the clearing cycle survives
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_fire && {waddr_r[11:2], 2'b00} == `LBD_OFF_IRQ_STAT && wstrb0_r) begin
            irq_stat_nxt = irq_stat_r & ~wdata_r[`LBD_EV_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | events;
    end

    // axi read path: one cycle after the address is taken
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end else if (!rvalid_r && s_axi_arvalid) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `LBD_RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                `LBD_OFF_CONFIG:   rdata_nxt = {25'h0, config_r};
                `LBD_OFF_STATUS:   rdata_nxt = {22'h0, irq_lvl_r, ack_r, req_r};
                `LBD_OFF_IRQ_STAT: rdata_nxt = {28'h0000000, irq_stat_r};
                `LBD_OFF_IRQ_MASK: rdata_nxt = {28'h0000000, irq_mask_r};
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = `LBD_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_r   <= `LBD_CONFIG_RST;
            irq_mask_r <= `LBD_IRQ_MASK_RST;
            irq_stat_r <= '0;
            irq_lvl_r  <= 2'h0;
            wstate_r   <= LBD_W_IDLE;
            aw_have_r  <= 1'b0;
            w_have_r   <= 1'b0;
            waddr_r    <= 12'h000;
            wdata_r    <= 32'h00000000;
            wstrb0_r   <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= 2'h0;
            rvalid_r   <= 1'b0;
            rdata_r    <= 32'h00000000;
            rresp_r    <= 2'h0;
            req_r      <= '0;
            ack_r      <= 4'h0;
        end else if (aclk_en) begin
            config_r   <= config_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_lvl_r  <= irq_lvl_nxt;
            wstate_r   <= wstate_nxt;
            aw_have_r  <= aw_have_nxt;
            w_have_r   <= w_have_nxt;
            waddr_r    <= waddr_nxt;
            wdata_r    <= wdata_nxt;
            wstrb0_r   <= wstrb0_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
            req_r      <= req_nxt;
            ack_r      <= ack_nxt;
        end
    end

    // ready is withheld while frozen so nothing is taken without being stored
    assign s_axi_awready = aclk_en && wstate_r == LBD_W_IDLE && !aw_have_r;
    assign s_axi_wready  = aclk_en && wstate_r == LBD_W_IDLE && !w_have_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = aclk_en && !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign chan_a_ack_line       = ack_r[0];
    assign chan_a_rx_ack         = ack_r[1];
    assign chan_b_tx_ack         = ack_r[2];
    assign chan_b_rx_ack         = ack_r[3];
    assign dma_req               = req_r;
    assign chan_a_irq            = irq_lvl_r[0];
    assign chan_b_irq            = irq_lvl_r[1];
    assign chan_a_irq_alt_decode = irq_in1_decode_select;
    assign chan_b_irq_alt_decode = separate_irq_pins ? irq_in2_decode_select
                                                     : irq_in1_decode_select;
    assign irq                   = |(irq_stat_r & irq_mask_r);
endmodule : lbd_top

// File: tb/lbd_top_monitor.sv
// port checker for the dma service mode block
`timescale 1ns/1ps
module lbd_top_monitor (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       chan_a_request_line,
    input wire logic       chan_a_rx_request,
    input wire logic       chan_b_tx_request,
    input wire logic       local_irq_input_one,
    input wire logic       local_irq_input_two,
    input wire logic       dma_a_tx_grant,
    input wire logic       dma_a_rx_grant,
    input wire logic       dma_b_tx_grant,
    input wire logic       chan_a_ack_line,
    input wire logic       chan_a_rx_ack,
    input wire logic       chan_b_tx_ack,
    input wire logic [3:0] dma_req,
    input wire logic       chan_a_irq,
    input wire logic       chan_b_irq,
    input wire logic       chan_a_irq_alt_decode,
    input wire logic       chan_b_irq_alt_decode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // request and irq pins pass two sync flops and a register, hence the depth of three; grants only a register
    property p_bak; chan_b_tx_ack |-> $past(dma_b_tx_grant); endproperty
    a_bak: assert property (p_bak) else $error("b ack without grant");
    property p_rak; chan_a_rx_ack |-> $past(dma_a_rx_grant); endproperty
    a_rak: assert property (p_rak) else $error("a rx ack without grant");
    property p_aak; chan_a_ack_line |-> $past(dma_a_tx_grant) || $past(dma_a_rx_grant); endproperty
    a_aak: assert property (p_aak) else $error("a ack without grant");
    property p_arq; dma_req[3] |-> $past(chan_a_rx_request, 3) || $past(chan_a_request_line, 3);
    endproperty
    a_arq: assert property (p_arq) else $error("a rx req without pin");
    property p_brq; dma_req[0] |-> $past(chan_b_tx_request, 3); endproperty
    a_brq: assert property (p_brq) else $error("b tx req without pin");
    // the level register was loaded under last cycle's decode bits, so look one back
    property p_ihi; chan_a_irq && !$past(chan_a_irq_alt_decode)
        |-> $past(local_irq_input_one, 3); endproperty
    a_ihi: assert property (p_ihi) else $error("a irq high decode wrong");
    property p_ilo; chan_a_irq && $past(chan_a_irq_alt_decode)
        |-> !$past(local_irq_input_one, 3); endproperty
    a_ilo: assert property (p_ilo) else $error("a irq low decode wrong");
    property p_ib; chan_b_irq && !$past(chan_b_irq_alt_decode) && !$past(chan_a_irq_alt_decode)
        |-> $past(local_irq_input_one, 3) || $past(local_irq_input_two, 3); endproperty
    a_ib: assert property (p_ib) else $error("b irq without pin");
endmodule : lbd_top_monitor
bind lbd_top lbd_top_monitor u_mon (.aclk, .aresetn, .chan_a_request_line, .chan_a_rx_request,
    .chan_b_tx_request, .local_irq_input_one, .local_irq_input_two, .dma_a_tx_grant,
    .dma_a_rx_grant, .dma_b_tx_grant, .chan_a_ack_line, .chan_a_rx_ack, .chan_b_tx_ack,
    .dma_req, .chan_a_irq, .chan_b_irq, .chan_a_irq_alt_decode, .chan_b_irq_alt_decode);

// File: tb/lbd_periph.sv
// serial controller model driving request and interrupt pins
`timescale 1ns/1ps
module lbd_periph (
    input wire logic       aclk,
    input wire logic [3:0] want_req,
    input wire logic [1:0] want_irq,
    output logic     [3:0] req_pins,
    output logic     [1:0] irq_pins
);
    initial begin
        req_pins = 4'h0;
        irq_pins = 2'h0;
    end
    // pins move just after an edge, never mid-cycle, like real peripheral logic
    always @(posedge aclk) begin
        req_pins <= want_req;
        irq_pins <= want_irq;
    end
endmodule : lbd_periph

// File: tb/lbd_top_test.sv
// self-checking bench for the dma service mode block
`timescale 1ns/1ps
`include "lbd_consts.svh"
module lbd_top_test;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic        aclk_en = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic        s_axi_awvalid = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic        s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic [3:0]  gnt = 4'h0;
    logic [3:0]  want_req = 4'h0;
    logic [1:0]  want_irq = 2'h0;
    logic [1:0]  resp;
    logic [31:0] rd;
    int          fails = 0;
    int          num_checks = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         chan_a_request_line, chan_a_rx_request, chan_b_tx_request, chan_b_rx_request;
    wire         local_irq_input_one, local_irq_input_two, irq, chan_a_irq, chan_b_irq;
    wire         chan_a_ack_line, chan_a_rx_ack, chan_b_tx_ack, chan_b_rx_ack;
    wire         chan_a_irq_alt_decode, chan_b_irq_alt_decode;
    wire  [3:0]  dma_req;
    wire  [3:0]  ack = {chan_a_rx_ack, chan_a_ack_line, chan_b_rx_ack, chan_b_tx_ack};

    always #2.5 aclk = ~aclk;

    lbd_top u_dut (
        .aclk, .aresetn, .aclk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_a_request_line,
        .chan_a_rx_request, .chan_b_tx_request, .chan_b_rx_request, .local_irq_input_one,
        .local_irq_input_two, .dma_a_rx_grant(gnt[3]), .dma_a_tx_grant(gnt[2]),
        .dma_b_rx_grant(gnt[1]), .dma_b_tx_grant(gnt[0]), .chan_a_ack_line, .chan_a_rx_ack,
        .chan_b_tx_ack, .chan_b_rx_ack, .dma_req, .chan_a_irq, .chan_b_irq,
        .chan_a_irq_alt_decode, .chan_b_irq_alt_decode, .irq
    );
    lbd_periph u_periph (
        .aclk, .want_req, .want_irq,
        .req_pins({chan_a_rx_request, chan_a_request_line, chan_b_rx_request, chan_b_tx_request}),
        .irq_pins({local_irq_input_two, local_irq_input_one})
    );

    task automatic finish_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic tmo;
        fails++;
        finish_test();
    endtask : tmo

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask : wt

    // each channel is released at its own ready; wait ends on bvalid or after 50 cycles
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n == 50) tmo();
        @(posedge aclk);
    endtask : axw

    task automatic axr(input logic [11:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n == 50) tmo();
        @(posedge aclk);
    endtask : axr

    initial begin
        int i;
        int k;
        logic ea;
        wt(6);
        aresetn <= 1'h1;
        wt(1);
        axr(`LBD_OFF_CONFIG);
        chk("config", 32'h0, rd);
        want_req <= 4'hF;
        gnt <= 4'hF;
        wt(5);
        chk("req off", 32'h0, dma_req);
        chk("ack off", 32'h0, ack);
        axw(`LBD_OFF_CONFIG, 32'h3);
        for (i = 0; i < 4; i++) begin
            want_req <= 4'h1 << i;
            gnt <= 4'h1 << i;
            wt(5);
            chk("req sep", 32'h1 << i, dma_req);
            chk("ack sep", 32'h1 << i, ack);
        end
        axw(`LBD_OFF_CONFIG, 32'h1);
        want_req <= 4'hF;
        gnt <= 4'hF;
        wt(5);
        chk("req a only", 32'hC, dma_req);
        chk("ack a only", 32'hC, ack);
        for (i = 0; i < 2; i++) begin
            axw(`LBD_OFF_CONFIG, 32'h7 | (i << 3));
            want_req <= 4'h4;
            gnt <= 4'h8;
            wt(5);
            chk("req shared", i ? 32'h4 : 32'h8, dma_req);
            chk("ack shared", 32'h4, ack);
        end
        axw(`LBD_OFF_CONFIG, 32'hB);
        want_req <= 4'h8;
        wt(5);
        chk("req dir off", 32'h8, dma_req);
        want_req <= 4'h0;
        gnt <= 4'h0;
        // sweep separate, decode two, decode one against all four pin levels
        for (k = 0; k < 32; k++) begin
            if (k % 4 == 0) axw(`LBD_OFF_CONFIG, 32'(k / 4) << 4);
            want_irq <= k[1:0];
            wt(5);
            ea = k[0] ^ k[2];
            chk("irq a", ea, chan_a_irq);
            chk("irq b", k[4] ? k[1] ^ k[3] : ea, chan_b_irq);
            chk("alt a", k[2], chan_a_irq_alt_decode);
            chk("alt b", k[4] ? k[3] : k[2], chan_b_irq_alt_decode);
        end
        want_irq <= 2'h0;
        axw(`LBD_OFF_CONFIG, 32'h1);
        wt(5);
        axw(`LBD_OFF_IRQ_STAT, 32'hF);
        axr(`LBD_OFF_IRQ_STAT);
        chk("stat clr", 32'h0, rd);
        axw(`LBD_OFF_IRQ_MASK, 32'h1);
        want_req <= 4'h4;
        wt(5);
        want_req <= 4'h0;
        wt(5);
        chk("irq set", 32'h1, irq);
        axr(`LBD_OFF_IRQ_STAT);
        chk("stat set", 32'h1, rd);
        axw(`LBD_OFF_IRQ_MASK, 32'h0);
        wt(2);
        chk("irq masked", 32'h0, irq);
        axw(`LBD_OFF_IRQ_MASK, 32'h1);
        axw(`LBD_OFF_IRQ_STAT, 32'h1);
        wt(2);
        chk("irq clr", 32'h0, irq);
        axr(12'h010);
        chk("bad rresp", 32'h2, resp);
        axw(12'h010, 32'h1);
        chk("bad bresp", 32'h2, resp);
        finish_test();
    end
endmodule : lbd_top_test
